//--- fbdcc_map.svh
`ifndef FBDCC_MAP_SVH
`define FBDCC_MAP_SVH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define FBDCC_UCM_OFS 12'h0D6
`define FBDCC_OPM_OFS 12'hD80
`define FBDCC_MMIO_OFS 12'hD81
`define FBDCC_CTL_OFS 12'hD82
`define FBDCC_STAT_OFS 12'hD83
`define FBDCC_MAP_OFS 12'hD84
`define FBDCC_CHN_OFS 12'hE00
// ----------------------------------------
// channel register slots
// ----------------------------------------
`define FBDCC_K_ADDR_LO 3'h0
`define FBDCC_K_ADDR_HI 3'h1
`define FBDCC_K_PAGE 3'h2
`define FBDCC_K_EXTPG 3'h3
`define FBDCC_K_CNT_LO 3'h4
`define FBDCC_K_CNT_MID 3'h5
`define FBDCC_K_CNT_HI 3'h6
`define FBDCC_K_MODE 3'h7
// ----------------------------------------
// field positions and encodings
// ----------------------------------------
`define FBDCC_OPM_ENH 0
`define FBDCC_OPM_W16_CH3 1
`define FBDCC_OPM_W16_CH5 2
`define FBDCC_CTL_REQ_LOW 0
`define FBDCC_CTL_ACK_HIGH 1
`define FBDCC_MODE_TYPE 2
`define FBDCC_MODE_DEC 5
`define FBDCC_MODE_XM 6
`define FBDCC_XM_DEMAND 2'h0
`define FBDCC_XM_SINGLE 2'h1
`define FBDCC_XM_BLOCK 2'h2
`define FBDCC_XM_CASCADE 2'h3
`define FBDCC_XT_VERIFY 2'h0
`define FBDCC_XT_WRITE 2'h1
`define FBDCC_XT_READ 2'h2
// ----------------------------------------
// reset values and timing
// ----------------------------------------
`define FBDCC_OPM_RST 8'h00
`define FBDCC_MMIO_RST 8'h00
`define FBDCC_CTL_RST 8'h00
`define FBDCC_MAP_RST 32'h00000000
`define FBDCC_CLK_NS 20
`define FBDCC_STROBE_NS 120
`endif

//--- fbdcc_periph_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// external peripheral handshake model
// ----------------------------------------
module fbdcc_periph_model (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [3:0] want,
  input wire logic [3:0] grant,
  output logic [3:0] request
);
  logic [3:0] pend_r;
  logic [3:0] gnt;
  // default polarities only: request high, grant low
  assign gnt = ~grant;
  always_ff @(posedge sys_clk) begin
    if (reset) pend_r <= 4'h0;
    else pend_r <= (pend_r | want) & ~gnt;
  end
  assign request = pend_r;
endmodule : fbdcc_periph_model

//--- fbdcc_pkg.sv
package fbdcc_pkg;
  typedef struct packed {
    logic [11:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } fbdcc_reg_req_t;
  typedef struct packed {
    logic [27:0] addr;
    logic wr;
    logic word;
  } fbdcc_mem_cmd_t;
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] page;
    logic [3:0] ext;
    logic [23:0] count;
    logic [7:0] mode;
    logic masked;
  } fbdcc_chan_t;
  typedef struct packed {
    logic io_read_strobe;
    logic io_write_strobe;
    logic mem_read_strobe;
    logic mem_write_strobe;
  } fbdcc_strobe_t;
  typedef enum logic [1:0] {
    FBDCC_IDLE,
    FBDCC_GRANT,
    FBDCC_STROBE,
    FBDCC_NEXT
  } fbdcc_state_t;
endpackage : fbdcc_pkg

//--- fbdcc_props.sv
`timescale 1ns/1ps
`include "fbdcc_map.svh"
// ----------------------------------------
// port checker
// ----------------------------------------
module fbdcc_props #(
  parameter int FIFO_DEPTH = 16,
  parameter int STROBE_NS = `FBDCC_STROBE_NS
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire fbdcc_pkg::fbdcc_reg_req_t reg_req,
  input wire logic [7:0] reg_rdata,
  input wire logic [3:0] uart_request_in,
  input wire logic [3:0] uart_grant_out,
  input wire logic [3:0] peripheral_request_in,
  input wire logic [3:0] peripheral_grant_out,
  input wire logic bus_address_enable_out,
  input wire logic [27:0] bus_address_lines,
  input wire logic terminal_count_out,
  input wire fbdcc_pkg::fbdcc_strobe_t bus_strobes,
  input wire fbdcc_pkg::fbdcc_mem_cmd_t mem_cmd,
  input wire logic mem_cmd_valid,
  input wire logic mem_cmd_ready
);
  import fbdcc_pkg::*;
  // same rounding as the engine: a partial cycle still counts whole
  localparam int STB_RAW = (STROBE_NS + `FBDCC_CLK_NS - 1) / `FBDCC_CLK_NS;
  localparam int STB_CYC = (STB_RAW < 1) ? 1 : STB_RAW;
  logic any_stb;
  logic [7:0] stb_cnt_r;
  logic [7:0] stb_cnt_nxt;
  assign any_stb = |bus_strobes;
  // counts strobe length; repetition would need a fixed literal
  always_comb stb_cnt_nxt = any_stb ? stb_cnt_r + 8'h01 : 8'h00;
  always_ff @(posedge sys_clk) begin
    if (reset) stb_cnt_r <= 8'h00;
    else stb_cnt_r <= stb_cnt_nxt;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  a_grant_aen: assert property (|uart_grant_out |-> bus_address_enable_out)
    else $error("uart grant without address enable");
  a_strobe_aen: assert property (any_stb |-> bus_address_enable_out)
    else $error("strobe outside address enable");
  // verify raises tc with no strobe, so only the address enable frames it
  a_tc_aen: assert property (terminal_count_out |-> bus_address_enable_out)
    else $error("terminal count outside transfer");
  a_strobe_len: assert property ($fell(any_stb) |-> stb_cnt_r == STB_CYC)
    else $error("strobe phase length wrong");
  a_one_grant: assert property ($onehot0(uart_grant_out))
    else $error("two uart grants at once");
  a_strobe_one: assert property ($onehot0(bus_strobes))
    else $error("two strobes at once");
  a_uart_iostb: assert property (|uart_grant_out |-> !bus_strobes.mem_read_strobe
    && !bus_strobes.mem_write_strobe) else $error("memory strobe on uart transfer");
  a_grant_cause: assert property (|(uart_grant_out & ~$past(uart_grant_out))
    |-> |(uart_grant_out & $past(uart_request_in))) else $error("grant without request");
  a_cmd_hold: assert property (mem_cmd_valid && !mem_cmd_ready
    |=> mem_cmd_valid && $stable(mem_cmd)) else $error("memory command dropped in stall");
  c_tc: cover property (terminal_count_out);
  c_stall: cover property (mem_cmd_valid && !mem_cmd_ready);
  c_mmio: cover property (bus_strobes.mem_read_strobe);
endmodule : fbdcc_props

//--- fbdcc_top.sv
`timescale 1ns/1ps
`include "fbdcc_map.svh"

module fbdcc_fifo #(
  parameter int W = 30,
  parameter int D = 16
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [W-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [W-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(D);
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } fbdcc_fifo_st_t;
  fbdcc_fifo_st_t st_r;
  fbdcc_fifo_st_t st_nxt;
  logic push;
  logic pop;

  assign in_ready = (st_r.cnt != (AW+1)'(D));
  assign out_valid = (st_r.cnt != '0);
  assign out_data = st_r.mem[st_r.rp];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    st_nxt = st_r;
    if (push) begin
      st_nxt.mem[st_r.wp] = in_data;
      st_nxt.wp = (st_r.wp == AW'(D-1)) ? '0 : st_r.wp + 1'b1;
    end
    if (pop) begin
      st_nxt.rp = (st_r.rp == AW'(D-1)) ? '0 : st_r.rp + 1'b1;
    end
    st_nxt.cnt = st_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule : fbdcc_fifo

module fbdcc_top #(
  parameter int FIFO_DEPTH = 16,
  parameter int STROBE_NS = `FBDCC_STROBE_NS
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire fbdcc_pkg::fbdcc_reg_req_t reg_req,
  output logic [7:0] reg_rdata,
  input wire logic [3:0] uart_request_in,
  output logic [3:0] uart_grant_out,
  input wire logic [3:0] peripheral_request_in,
  output logic [3:0] peripheral_grant_out,
  output logic bus_address_enable_out,
  output logic [27:0] bus_address_lines,
  output logic terminal_count_out,
  output fbdcc_pkg::fbdcc_strobe_t bus_strobes,
  output fbdcc_pkg::fbdcc_mem_cmd_t mem_cmd,
  output logic mem_cmd_valid,
  input wire logic mem_cmd_ready
);
  import fbdcc_pkg::*;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int STB_RAW = (STROBE_NS + `FBDCC_CLK_NS - 1) / `FBDCC_CLK_NS;
  localparam int STB_CYC = (STB_RAW < 1) ? 1 : STB_RAW;

  typedef struct packed {
    fbdcc_chan_t [7:0] ch;
    logic [7:0] ctl;
    logic [7:0] opm;
    logic [7:0] mmio;
    logic [31:0] map;
    logic [7:0] tcf;
    logic [7:0] rdata;
    logic [3:0] s1;
    logic [3:0] s2;
    logic [3:0] s3;
    logic [3:0] ereq;
    fbdcc_state_t fsm;
    logic [2:0] chn;
    logic [2:0] src;
    logic [7:0] tmr;
    logic [27:0] maddr;
    fbdcc_strobe_t stb;
    logic aen;
    logic tc;
    logic [7:0] gnt;
  } fbdcc_st_t;

  fbdcc_st_t st_r;
  fbdcc_st_t st_nxt;

  // ----------------------------------------
  // channel width and enhancement
  // ----------------------------------------
  function automatic logic f_is16(input logic [2:0] c, input logic [7:0] m);
    logic r;
    r = 1'b0;
    if (c == 3'h3) begin
      r = m[`FBDCC_OPM_ENH] && m[`FBDCC_OPM_W16_CH3];
    end else if (c > 3'h4) begin
      r = !m[`FBDCC_OPM_ENH] || m[`FBDCC_OPM_W16_CH5 + int'(c) - 5];
    end
    return r;
  endfunction : f_is16

  function automatic logic f_enh(input logic [2:0] c, input logic [7:0] m);
    return m[`FBDCC_OPM_ENH] && (c == 3'h3 || c > 3'h4);
  endfunction : f_enh

  // ----------------------------------------
  // request sources
  // ----------------------------------------
  logic [7:0] sreq;
  logic [7:0] src_ok;
  logic [7:0] src_act;
  logic [7:0][2:0] src_ch;

  // memory is never a source, only peripherals
  assign sreq = {st_r.ereq ^ {4{st_r.ctl[`FBDCC_CTL_REQ_LOW]}}, uart_request_in};

  for (genvar g = 0; g < 8; g++) begin : g_src
    assign src_ch[g] = st_r.map[4*g +: 3];
    if (g < 4) begin : g_uart
      // byte-only sources dropped on wide channels
      assign src_ok[g] = st_r.map[4*g+3] && (src_ch[g] < 3'h4)
                         && !f_is16(src_ch[g], st_r.opm);
    end else begin : g_ext
      assign src_ok[g] = st_r.map[4*g+3] && (src_ch[g] != 3'h4);
    end
    assign src_act[g] = sreq[g] && src_ok[g];
  end

  // ----------------------------------------
  // fixed priority arbitration
  // ----------------------------------------
  logic win_v;
  logic [2:0] win_ch;
  logic [2:0] win_src;

  always_comb begin
    win_v = 1'b0;
    win_ch = 3'h0;
    win_src = 3'h0;
    for (int c = 7; c >= 0; c--) begin
      for (int s = 7; s >= 0; s--) begin
        // channel 4 never wins: it only cascades
        if (src_act[s] && src_ch[s] == 3'(c) && c != 4 && !st_r.ch[c].masked
            && st_r.ch[c].mode[`FBDCC_MODE_XM +: 2] != `FBDCC_XM_CASCADE) begin
          win_v = 1'b1;
          win_ch = 3'(c);
          win_src = 3'(s);
        end
      end
    end
  end

  // ----------------------------------------
  // active channel datapath
  // ----------------------------------------
  fbdcc_chan_t cur;
  logic w16;
  logic enh_c;
  logic last;
  logic is_rd;
  logic is_wr;
  logic mmio_c;
  logic [1:0] xm;
  logic [27:0] lin;
  logic [27:0] nlin;
  logic [27:0] maddr;
  logic [15:0] n_addr;
  logic [7:0] n_page;
  logic [3:0] n_ext;
  logic [23:0] n_cnt;

  always_comb begin
    cur = st_r.ch[st_r.chn];
    w16 = f_is16(st_r.chn, st_r.opm);
    enh_c = f_enh(st_r.chn, st_r.opm);
    xm = cur.mode[`FBDCC_MODE_XM +: 2];
    // reserved type code acts as verify, so no other pairing exists
    is_rd = cur.mode[`FBDCC_MODE_TYPE +: 2] == `FBDCC_XT_READ;
    is_wr = cur.mode[`FBDCC_MODE_TYPE +: 2] == `FBDCC_XT_WRITE;
    mmio_c = st_r.src[2] && st_r.mmio[st_r.src[1:0]];
    if (w16) begin
      maddr = {cur.ext, cur.page[7:1], cur.addr, 1'b0};
      lin = {1'b0, cur.ext, cur.page[7:1], cur.addr};
    end else begin
      maddr = {cur.ext, cur.page, cur.addr};
      lin = {cur.ext, cur.page, cur.addr};
    end
    nlin = cur.mode[`FBDCC_MODE_DEC] ? lin - 28'h1 : lin + 28'h1;
    // page and extended page stay put unless the wide adder is on
    n_addr = nlin[15:0];
    n_page = cur.page;
    n_ext = cur.ext;
    if (enh_c && w16) begin
      {n_ext, n_page[7:1]} = nlin[26:16];
    end else if (enh_c) begin
      {n_ext, n_page} = nlin[27:16];
    end
    last = enh_c ? (cur.count == 24'h0) : (cur.count[15:0] == 16'h0);
    n_cnt = enh_c ? cur.count - 24'h1 : {cur.count[23:16], cur.count[15:0] - 16'h1};
  end

  // ----------------------------------------
  // memory command queue
  // ----------------------------------------
  logic fifo_in_valid;
  logic fifo_in_ready;
  fbdcc_mem_cmd_t cmd;

  // only address, direction and width are queued; data flies past on the bus
  assign cmd = '{addr: maddr, wr: is_wr, word: w16};
  assign fifo_in_valid = (st_r.fsm == FBDCC_GRANT) && (is_rd || is_wr);

  fbdcc_fifo #(
    .W($bits(fbdcc_mem_cmd_t)),
    .D(FIFO_DEPTH)
  ) u_fifo (
    .sys_clk(sys_clk),
    .reset(reset),
    .in_data(cmd),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .out_data(mem_cmd),
    .out_valid(mem_cmd_valid),
    .out_ready(mem_cmd_ready)
  );

  // ----------------------------------------
  // next state
  // ----------------------------------------
  logic [11:0] ra;
  logic [2:0] rc;
  logic [2:0] rk;
  logic keep;

  assign ra = reg_req.addr;
  assign rc = ra[5:3];
  assign rk = ra[2:0];

  always_comb begin
    st_nxt = st_r;
    keep = 1'b0;
    // first stage feeds only the second
    st_nxt.s1 = peripheral_request_in;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    if (st_r.s2 == st_r.s3) begin
      st_nxt.ereq = st_r.s3;
    end
    if (reg_req.rd) begin
      st_nxt.rdata = 8'h00;
      if (ra == `FBDCC_OPM_OFS) begin
        st_nxt.rdata = st_r.opm;
      end else if (ra == `FBDCC_MMIO_OFS) begin
        st_nxt.rdata = st_r.mmio;
      end else if (ra == `FBDCC_CTL_OFS) begin
        st_nxt.rdata = st_r.ctl;
      end else if (ra == `FBDCC_STAT_OFS) begin
        st_nxt.rdata = st_r.tcf;
        st_nxt.tcf = 8'h00;
      end else if (ra[11:2] == `FBDCC_MAP_OFS >> 2) begin
        st_nxt.rdata = st_r.map[8*ra[1:0] +: 8];
      end else if (ra[11:6] == `FBDCC_CHN_OFS >> 6) begin
        case (rk)
          `FBDCC_K_ADDR_LO: st_nxt.rdata = st_r.ch[rc].addr[7:0];
          `FBDCC_K_ADDR_HI: st_nxt.rdata = st_r.ch[rc].addr[15:8];
          `FBDCC_K_PAGE: st_nxt.rdata = st_r.ch[rc].page;
          `FBDCC_K_EXTPG: st_nxt.rdata = {4'h0, st_r.ch[rc].ext};
          `FBDCC_K_CNT_LO: st_nxt.rdata = st_r.ch[rc].count[7:0];
          `FBDCC_K_CNT_MID: st_nxt.rdata = st_r.ch[rc].count[15:8];
          `FBDCC_K_CNT_HI: st_nxt.rdata = st_r.ch[rc].count[23:16];
          default: st_nxt.rdata = st_r.ch[rc].mode;
        endcase
      end
    end
    if (reg_req.wr) begin
      if (ra == `FBDCC_OPM_OFS) begin
        st_nxt.opm = reg_req.wdata;
      end else if (ra == `FBDCC_MMIO_OFS) begin
        st_nxt.mmio = reg_req.wdata;
      end else if (ra == `FBDCC_CTL_OFS) begin
        st_nxt.ctl = reg_req.wdata;
      end else if (ra == `FBDCC_UCM_OFS) begin
        st_nxt.ch[{1'b1, reg_req.wdata[1:0]}].mode = reg_req.wdata;
        st_nxt.ch[{1'b1, reg_req.wdata[1:0]}].masked = 1'b0;
      end else if (ra[11:2] == `FBDCC_MAP_OFS >> 2) begin
        st_nxt.map[8*ra[1:0] +: 8] = reg_req.wdata;
      end else if (ra[11:6] == `FBDCC_CHN_OFS >> 6) begin
        case (rk)
          `FBDCC_K_ADDR_LO: st_nxt.ch[rc].addr[7:0] = reg_req.wdata;
          `FBDCC_K_ADDR_HI: st_nxt.ch[rc].addr[15:8] = reg_req.wdata;
          `FBDCC_K_PAGE: st_nxt.ch[rc].page = reg_req.wdata;
          `FBDCC_K_EXTPG: st_nxt.ch[rc].ext = reg_req.wdata[3:0];
          `FBDCC_K_CNT_LO: st_nxt.ch[rc].count[7:0] = reg_req.wdata;
          `FBDCC_K_CNT_MID: st_nxt.ch[rc].count[15:8] = reg_req.wdata;
          `FBDCC_K_CNT_HI: st_nxt.ch[rc].count[23:16] = reg_req.wdata;
          default: begin
            st_nxt.ch[rc].mode = reg_req.wdata;
            st_nxt.ch[rc].masked = 1'b0;
          end
        endcase
      end
    end
    // transfer engine last, so a terminal count beats a status read
    case (st_r.fsm)
      FBDCC_IDLE: begin
        if (win_v) begin
          st_nxt.chn = win_ch;
          st_nxt.src = win_src;
          st_nxt.gnt = 8'h01 << win_src;
          st_nxt.aen = 1'b1;
          st_nxt.fsm = FBDCC_GRANT;
        end
      end
      FBDCC_GRANT: begin
        st_nxt.maddr = maddr;
        // a full queue holds the grant and stalls the bus cycle
        if (!(is_rd || is_wr) || fifo_in_ready) begin
          st_nxt.fsm = FBDCC_STROBE;
          st_nxt.tmr = 8'(STB_CYC - 1);
          st_nxt.tc = last;
          // verify raises no strobe at all
          st_nxt.stb.io_write_strobe = is_rd && !mmio_c;
          st_nxt.stb.mem_write_strobe = is_rd && mmio_c;
          st_nxt.stb.io_read_strobe = is_wr && !mmio_c;
          st_nxt.stb.mem_read_strobe = is_wr && mmio_c;
        end
      end
      FBDCC_STROBE: begin
        if (st_r.tmr == 8'h00) begin
          st_nxt.stb = '0;
          st_nxt.tc = 1'b0;
          st_nxt.fsm = FBDCC_NEXT;
        end else begin
          st_nxt.tmr = st_r.tmr - 8'h01;
        end
      end
      FBDCC_NEXT: begin
        st_nxt.ch[st_r.chn].addr = n_addr;
        st_nxt.ch[st_r.chn].page = n_page;
        st_nxt.ch[st_r.chn].ext = n_ext;
        st_nxt.ch[st_r.chn].count = n_cnt;
        if (last) begin
          st_nxt.tcf[st_r.chn] = 1'b1;
          st_nxt.ch[st_r.chn].masked = 1'b1;
        end
        // demand stops once the peripheral drops its request
        keep = !last && (xm == `FBDCC_XM_BLOCK
               || (xm == `FBDCC_XM_DEMAND && src_act[st_r.src]));
        if (keep) begin
          st_nxt.fsm = FBDCC_GRANT;
        end else begin
          st_nxt.fsm = FBDCC_IDLE;
          st_nxt.gnt = 8'h00;
          st_nxt.aen = 1'b0;
        end
      end
      default: st_nxt.fsm = FBDCC_IDLE;
    endcase
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      st_r <= '0;
      st_r.ctl <= `FBDCC_CTL_RST;
      st_r.opm <= `FBDCC_OPM_RST;
      st_r.mmio <= `FBDCC_MMIO_RST;
      st_r.map <= `FBDCC_MAP_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign reg_rdata = st_r.rdata;
  assign uart_grant_out = st_r.gnt[3:0];
  assign peripheral_grant_out = st_r.gnt[7:4] ^ {4{!st_r.ctl[`FBDCC_CTL_ACK_HIGH]}};
  assign bus_address_enable_out = st_r.aen;
  assign bus_address_lines = st_r.maddr;
  assign terminal_count_out = st_r.tc;
  assign bus_strobes = st_r.stb;
endmodule : fbdcc_top

//--- test_fly_by_dma_channel_control.sv
`timescale 1ns/1ps
`include "fbdcc_map.svh"
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
`define WAITC(c) begin for (int w = 0; w < 400 && !(c); w++) @(posedge sys_clk); \
  if (!(c)) begin n_mismatch++; $display("MISMATCH wait exp 1 got 0"); end end
module test_fly_by_dma_channel_control;
  import fbdcc_pkg::*;
  logic sys_clk;
  logic reset;
  fbdcc_reg_req_t reg_req;
  logic [7:0] reg_rdata;
  logic [3:0] uart_request_in;
  logic [3:0] uart_grant_out;
  logic [3:0] peripheral_request_in;
  logic [3:0] peripheral_grant_out;
  logic bus_address_enable_out;
  logic [27:0] bus_address_lines;
  logic terminal_count_out;
  fbdcc_strobe_t bus_strobes;
  fbdcc_mem_cmd_t mem_cmd;
  logic mem_cmd_valid;
  logic mem_cmd_ready;
  logic [3:0] want;
  int n_mismatch;
  int n_checks;
  fbdcc_top fbdcc_top_i (.sys_clk(sys_clk), .reset(reset), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .uart_request_in(uart_request_in), .uart_grant_out(uart_grant_out),
    .peripheral_request_in(peripheral_request_in), .peripheral_grant_out(peripheral_grant_out),
    .bus_address_enable_out(bus_address_enable_out), .bus_address_lines(bus_address_lines),
    .terminal_count_out(terminal_count_out), .bus_strobes(bus_strobes), .mem_cmd(mem_cmd),
    .mem_cmd_valid(mem_cmd_valid), .mem_cmd_ready(mem_cmd_ready));
  fbdcc_periph_model fbdcc_periph_model_i (.sys_clk(sys_clk), .reset(reset), .want(want),
    .grant(peripheral_grant_out), .request(peripheral_request_in));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic complete_run();
    if (n_mismatch == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : complete_run
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_req <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(posedge sys_clk);
    reg_req <= '0;
  endtask : wr
  task automatic rchk(input string nm, input logic [11:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    reg_req <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    @(posedge sys_clk);
    reg_req <= '0;
    #1;
    `CHK(nm, e, reg_rdata)
  endtask : rchk
  task automatic chan(input int c, input logic [15:0] ad, input logic [7:0] pg,
    input logic [3:0] ep, input logic [15:0] cnt, input logic [7:0] md);
    logic [11:0] b;
    b = `FBDCC_CHN_OFS + 12'(8 * c);
    wr(b, ad[7:0]);
    wr(b + 12'h1, ad[15:8]);
    wr(b + 12'h2, pg);
    wr(b + 12'h3, {4'h0, ep});
    wr(b + 12'h4, cnt[7:0]);
    wr(b + 12'h5, cnt[15:8]);
    wr(b + 12'h6, 8'h00);
    wr(b + 12'h7, md);
  endtask : chan
  task automatic pop(input string nm, input logic [27:0] ea, input logic ew, input logic eb);
    `WAITC(mem_cmd_valid === 1'b1 && mem_cmd_ready === 1'b1)
    `CHK(nm, {ea, ew, eb}, mem_cmd)
    @(posedge sys_clk);
  endtask : pop
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    `CHK("idle ext grant", 4'hF, peripheral_grant_out)
    `CHK("idle uart grant", 4'h0, uart_grant_out)
    `CHK("idle aen", 1'b0, bus_address_enable_out)
    rchk("opmode", `FBDCC_OPM_OFS, 8'h00);
    rchk("mmio", `FBDCC_MMIO_OFS, 8'h00);
    rchk("ctl", `FBDCC_CTL_OFS, 8'h00);
    wr(`FBDCC_UCM_OFS, 8'hC0);
    rchk("write only", `FBDCC_UCM_OFS, 8'h00);
    rchk("unmapped", 12'hABC, 8'h00);
    wr(`FBDCC_OPM_OFS, 8'h01);
    rchk("opmode rw", `FBDCC_OPM_OFS, 8'h01);
    wr(`FBDCC_OPM_OFS, 8'h00);
    wr(`FBDCC_CTL_OFS, 8'h02);
    repeat (3) @(posedge sys_clk);
    `CHK("ack high", 4'h0, peripheral_grant_out)
    wr(`FBDCC_CTL_OFS, 8'h00);
  endtask : t_reset
  task automatic t_uart_wrap();
    wr(`FBDCC_MAP_OFS, 8'h0A);
    chan(2, 16'hFFFF, 8'h12, 4'h3, 16'h0001, 8'h88);
    uart_request_in[0] <= 1'b1;
    `WAITC(uart_grant_out[0] === 1'b1)
    `CHK("uart grant", 1'b1, uart_grant_out[0])
    uart_request_in[0] <= 1'b0;
    `WAITC(|bus_strobes)
    `CHK("uart strobe", 4'b0100, bus_strobes)
    `CHK("no tc", 1'b0, terminal_count_out)
    `CHK("bus addr", 28'h312FFFF, bus_address_lines)
    pop("first addr", 28'h312FFFF, 1'b0, 1'b0);
    pop("page wrap", 28'h3120000, 1'b0, 1'b0);
    `CHK("tc pin", 1'b1, terminal_count_out)
    `WAITC(!bus_address_enable_out)
    rchk("tc flag", `FBDCC_STAT_OFS, 8'h04);
    rchk("tc clear", `FBDCC_STAT_OFS, 8'h00);
  endtask : t_uart_wrap
  task automatic t_ext16();
    wr(`FBDCC_MMIO_OFS, 8'h01);
    wr(`FBDCC_MAP_OFS + 12'h2, 8'h0D);
    chan(5, 16'h1234, 8'h57, 4'hA, 16'h0001, 8'h84);
    mem_cmd_ready <= 1'b0;
    want <= 4'h1;
    @(posedge sys_clk);
    want <= 4'h0;
    `WAITC(|bus_strobes)
    `CHK("mmio strobe", 4'b0010, bus_strobes)
    `CHK("ext grant", 4'hE, peripheral_grant_out)
    `WAITC(!bus_address_enable_out)
    `CHK("stalled cmd", 1'b1, mem_cmd_valid)
    mem_cmd_ready <= 1'b1;
    pop("word addr", 28'hA562468, 1'b1, 1'b1);
    pop("word next", 28'hA56246A, 1'b1, 1'b1);
    rchk("tc ch5", `FBDCC_STAT_OFS, 8'h20);
    wr(`FBDCC_MMIO_OFS, 8'h00);
  endtask : t_ext16
  task automatic t_prio();
    wr(`FBDCC_MAP_OFS, 8'h9D);
    wr(`FBDCC_MAP_OFS + 12'h1, 8'h08);
    chan(0, 16'h0040, 8'h00, 4'h0, 16'h0000, 8'h40);
    chan(1, 16'h0080, 8'h00, 4'h0, 16'h0000, 8'h44);
    // re-arm ch5 so only the map check can keep src0 out
    wr(`FBDCC_CHN_OFS + 12'h2F, 8'h48);
    uart_request_in <= 4'b0111;
    `WAITC(|uart_grant_out)
    `CHK("first winner", 4'b0100, uart_grant_out)
    @(posedge sys_clk);
    `CHK("verify quiet", 4'h0, bus_strobes)
    `CHK("verify tc", 1'b1, terminal_count_out)
    uart_request_in[2] <= 1'b0;
    `WAITC(uart_grant_out === 4'b0010)
    `CHK("second winner", 4'b0010, uart_grant_out)
    uart_request_in[1] <= 1'b0;
    `WAITC(|bus_strobes)
    `CHK("uart rx strobe", 4'b1000, bus_strobes)
    // src0 sits on a 16-bit channel and must stay unserved
    repeat (40) begin @(posedge sys_clk); `CHK("refused", 1'b0, uart_grant_out[0]) end
    uart_request_in <= 4'h0;
  endtask : t_prio
  task automatic t_enh();
    wr(`FBDCC_OPM_OFS, 8'h01);
    wr(`FBDCC_MAP_OFS + 12'h1, 8'hB0);
    chan(3, 16'hFFFF, 8'h12, 4'h3, 16'h0001, 8'h88);
    uart_request_in[3] <= 1'b1;
    `WAITC(uart_grant_out[3] === 1'b1)
    `CHK("enh grant", 1'b1, uart_grant_out[3])
    uart_request_in[3] <= 1'b0;
    pop("enh first", 28'h312FFFF, 1'b0, 1'b0);
    pop("enh carry", 28'h3130000, 1'b0, 1'b0);
    wr(`FBDCC_OPM_OFS, 8'h00);
  endtask : t_enh
  // ----------------------------------------
  // run control
  // ----------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  initial begin
    reset = 1'b1;
    reg_req = '0;
    uart_request_in = 4'h0;
    want = 4'h0;
    mem_cmd_ready = 1'b1;
    n_mismatch = 0;
    n_checks = 0;
    repeat (16) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    t_reset();
    t_uart_wrap();
    t_ext16();
    t_prio();
    t_enh();
    complete_run();
  end
  // generous bound: whole sequence needs well under 3000 cycles
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_mismatch++;
    $display("MISMATCH watchdog exp 0 got 1");
    complete_run();
  end
endmodule : test_fly_by_dma_channel_control
bind fbdcc_top fbdcc_props #(.FIFO_DEPTH(FIFO_DEPTH), .STROBE_NS(STROBE_NS)) fbdcc_props_i (
  .sys_clk(sys_clk), .reset(reset), .reg_req(reg_req), .reg_rdata(reg_rdata),
  .uart_request_in(uart_request_in), .uart_grant_out(uart_grant_out),
  .peripheral_request_in(peripheral_request_in), .peripheral_grant_out(peripheral_grant_out),
  .bus_address_enable_out(bus_address_enable_out), .bus_address_lines(bus_address_lines),
  .terminal_count_out(terminal_count_out), .bus_strobes(bus_strobes), .mem_cmd(mem_cmd),
  .mem_cmd_valid(mem_cmd_valid), .mem_cmd_ready(mem_cmd_ready));
